// ### ps_cmd_defines.vh
// constants for the supply management command handler
`ifndef PS_CMD_DEFINES_VH
`define PS_CMD_DEFINES_VH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define PS_CMD_OUTPUT_CTRL  8'h01
`define PS_CMD_CLEAR_FAULTS 8'h03
`define PS_CMD_WRITE_LOCK   8'h10
`define PS_CMD_RST_DEF_ALL  8'h12
`define PS_CMD_RST_DEF_ONE  8'h14
`define PS_CMD_RST_USER_ALL 8'h16
`define PS_CMD_STORE_USER   8'h17
`define PS_CMD_RST_USER_ONE 8'h18
`define PS_CMD_FORMAT       8'h20
`define PS_CMD_SETPOINT     8'h21
`define PS_CMD_VIN_ON       8'h35
`define PS_CMD_VIN_OFF      8'h36
`define PS_CMD_FAN_CFG      8'h3A
`define PS_CMD_FAN_OVR      8'h3B
`define PS_CMD_OV_LIMIT     8'h40
`define PS_CMD_OV_ACTION    8'h41
`define PS_CMD_HI_WARN      8'h42
`define PS_CMD_LO_WARN      8'h43
`define PS_CMD_UV_LIMIT     8'h44
`define PS_CMD_UV_ACTION    8'h45
`define PS_CMD_OC_LIMIT     8'h46
`define PS_CMD_OC_ACTION    8'h47

// ---------------------------------------------------------------
// data values
// ---------------------------------------------------------------
`define PS_OUT_ON           8'h80
`define PS_OUT_OFF          8'h00
`define PS_LOCK_NONE        8'h00
`define PS_LOCK_ALL         8'h80
`define PS_LOCK_BUT_OUTPUT  8'h40
`define PS_RESP_LATCH_UV    8'h80
`define PS_RESP_RESTART_UV  8'hC0
`define PS_RESP_LATCH_OC    8'hC0
`define PS_RESP_HICCUP_OC   8'hF8
`define PS_OV_ACTION_VAL    8'h80
`define PS_FAN_CFG_VAL      8'h90
`define PS_FAN_FULL         8'h64
`define PS_FAN_INTERNAL     8'h00
`define PS_MODE_LINEAR      3'h0
`define PS_VOUT_EXP         5'h17
`define PS_OV_RETRIES       2'h3

// ---------------------------------------------------------------
// factory defaults, voltages in linear units of the fixed exponent
// ---------------------------------------------------------------
`define PS_DEF_SETPOINT     16'h1800
`define PS_DEF_OV_LIMIT     16'h1D9A
`define PS_DEF_HI_WARN      16'h1B9A
`define PS_DEF_LO_WARN      16'h159A
`define PS_DEF_UV_LIMIT     16'h1400
`define PS_DEF_OC_LIMIT     16'h0044
`define PS_OC_LOWLINE_LIMIT 16'h002D
`define PS_VIN_ON_LOW       16'h005A
`define PS_VIN_OFF_LOW      16'h0050
`define PS_VIN_ON_HIGH      16'h00B4
`define PS_VIN_OFF_HIGH     16'h00AA

// ---------------------------------------------------------------
// settings table slots
// ---------------------------------------------------------------
`define PS_IX_SETPOINT      3'h0
`define PS_IX_OV_LIMIT      3'h1
`define PS_IX_HI_WARN       3'h2
`define PS_IX_LO_WARN       3'h3
`define PS_IX_UV_LIMIT      3'h4
`define PS_IX_UV_ACTION     3'h5
`define PS_IX_OC_LIMIT      3'h6
`define PS_IX_OC_ACTION     3'h7

// ---------------------------------------------------------------
// timing: clock rate, tick, retry delay and window
// ---------------------------------------------------------------
`define PS_CLK_MHZ          250
`define PS_TICK_US          1000
`define PS_RETRY_MS         1000
`define PS_WINDOW_MS        60000

`endif

// ### ps_cmd_handler.v
// management bus command handler of a rack power supply
//
// Functional notes
// - output control accepts 0x80 on, 0x00 off
// - off then on restart clears alarms, shutdowns
// - fault clear only from side in control
// - still present faults set again after clear
// - write lock decodes 00, 80, 40
// - reads always work; lock writes always accepted
// - lock resets open, never stored as user
// - restore all reloads factory defaults
// - single restore factory, store user, restore user
// - format byte linear, fixed exponent
// - set-point writable, override pin wins restart after off, not power-up
// - input thresholds read-only, line dependent
// - fan configured for duty cycle only
// - fan override percent, below required errors
// - overvoltage limit shuts output down
// - overvoltage retries thrice, latches within window
// - latch released by pin or command cycle
// - alert on high or low warning
// - undervoltage shutdown masked on input dropout
// - undervoltage response only latch or restart
// - overcurrent limit fixed at low line
// - overcurrent response only latch or hiccup
`timescale 1ns/1ps
`include "ps_cmd_defines.vh"

module ps_cmd_handler #(
  parameter [6:0] SLAVE_ADDR = 7'h58,
  parameter TICK_CYCLES = `PS_CLK_MHZ * `PS_TICK_US,
  parameter [16:0] RETRY_TICKS = `PS_RETRY_MS,
  parameter [16:0] WINDOW_TICKS = `PS_WINDOW_MS
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n_o,
  input wire ctrl_side_i,
  input wire on_pin_i,
  input wire high_line_i,
  input wire input_dropout_i,
  input wire setpoint_pin_sel_i,
  input wire [15:0] setpoint_pin_i,
  input wire [15:0] vout_meas_i,
  input wire [15:0] iout_meas_i,
  input wire [7:0] fan_min_duty_i,
  output reg main_on_o,
  output reg [15:0] setpoint_o,
  output reg [7:0] fan_duty_o,
  output reg [7:0] fault_flags_o,
  output reg latched_off_o,
  output reg alert_n_o
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [1:0] scl_q, sda_q;
  reg scl_d, sda_d;
  reg [7:0] lvl_a, lvl_b;
  reg [15:0] vsp_a, vsp_b, vm_a, vm_b, im_a, im_b;
  reg [7:0] fmin_a, fmin_b;
  wire ctrl_side = lvl_b[0];
  wire pin_on = lvl_b[1];
  wire high_line = lvl_b[2];
  wire dropout = lvl_b[3];
  wire sp_pin_sel = lvl_b[4];

  // two flops on every pin; third scl/sda flop is for edge finding only
  always @(posedge mclk_i) begin
    scl_q <= {scl_q[0], scl_i};
    sda_q <= {sda_q[0], sda_i};
    scl_d <= scl_q[1];
    sda_d <= sda_q[1];
    lvl_a <= {3'h0, setpoint_pin_sel_i, input_dropout_i, high_line_i, on_pin_i, ctrl_side_i};
    lvl_b <= lvl_a;
    vsp_a <= setpoint_pin_i;
    vsp_b <= vsp_a;
    vm_a <= vout_meas_i;
    vm_b <= vm_a;
    im_a <= iout_meas_i;
    im_b <= im_a;
    fmin_a <= fan_min_duty_i;
    fmin_b <= fmin_a;
  end

  wire scl_rise = scl_q[1] & ~scl_d;
  wire scl_fall = ~scl_q[1] & scl_d;
  wire bus_start = scl_q[1] & scl_d & sda_d & ~sda_q[1];
  wire bus_stop = scl_q[1] & scl_d & ~sda_d & sda_q[1];

  // ---------------------------------------------------------------
  // settings table helpers
  // ---------------------------------------------------------------
  // slot of a storable setting; bit 3 set when the code has none
  function [3:0] slot_of;
    input [7:0] code;
    begin
      case (code)
        `PS_CMD_SETPOINT: slot_of = {1'b0, `PS_IX_SETPOINT};
        `PS_CMD_OV_LIMIT: slot_of = {1'b0, `PS_IX_OV_LIMIT};
        `PS_CMD_HI_WARN: slot_of = {1'b0, `PS_IX_HI_WARN};
        `PS_CMD_LO_WARN: slot_of = {1'b0, `PS_IX_LO_WARN};
        `PS_CMD_UV_LIMIT: slot_of = {1'b0, `PS_IX_UV_LIMIT};
        `PS_CMD_UV_ACTION: slot_of = {1'b0, `PS_IX_UV_ACTION};
        `PS_CMD_OC_LIMIT: slot_of = {1'b0, `PS_IX_OC_LIMIT};
        `PS_CMD_OC_ACTION: slot_of = {1'b0, `PS_IX_OC_ACTION};
        default: slot_of = 4'h8;
      endcase
    end
  endfunction

  // fixed factory values, never writable
  function [15:0] factory;
    input [2:0] ix;
    begin
      case (ix)
        `PS_IX_SETPOINT: factory = `PS_DEF_SETPOINT;
        `PS_IX_OV_LIMIT: factory = `PS_DEF_OV_LIMIT;
        `PS_IX_HI_WARN: factory = `PS_DEF_HI_WARN;
        `PS_IX_LO_WARN: factory = `PS_DEF_LO_WARN;
        `PS_IX_UV_LIMIT: factory = `PS_DEF_UV_LIMIT;
        `PS_IX_UV_ACTION: factory = {8'h00, `PS_RESP_RESTART_UV};
        `PS_IX_OC_LIMIT: factory = `PS_DEF_OC_LIMIT;
        default: factory = {8'h00, `PS_RESP_HICCUP_OC};
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // command state and read-back mux
  // ---------------------------------------------------------------
  reg [15:0] cfg [0:7];
  reg [15:0] user [0:7];
  reg out_cmd_on;
  reg [7:0] lock;
  reg [7:0] fan_ovr;
  reg [7:0] cmd, d0, d1;
  reg [2:0] nbytes;
  reg rw;
  reg tx_hi;
  reg [15:0] rd_word;
  wire [3:0] rd_slot = slot_of(cmd);

  // every supported code reads regardless of lock
  always @* begin
    case (cmd)
      `PS_CMD_OUTPUT_CTRL: rd_word = {8'h00, out_cmd_on ? `PS_OUT_ON : `PS_OUT_OFF};
      `PS_CMD_WRITE_LOCK: rd_word = {8'h00, lock};
      `PS_CMD_FORMAT: rd_word = {8'h00, `PS_MODE_LINEAR, `PS_VOUT_EXP};
      `PS_CMD_VIN_ON: rd_word = high_line ? `PS_VIN_ON_HIGH : `PS_VIN_ON_LOW;
      `PS_CMD_VIN_OFF: rd_word = high_line ? `PS_VIN_OFF_HIGH : `PS_VIN_OFF_LOW;
      `PS_CMD_FAN_CFG: rd_word = {8'h00, `PS_FAN_CFG_VAL};
      `PS_CMD_FAN_OVR: rd_word = {8'h00, fan_ovr};
      `PS_CMD_OV_ACTION: rd_word = {8'h00, `PS_OV_ACTION_VAL};
      default: rd_word = rd_slot[3] ? 16'h0000 : cfg[rd_slot[2:0]];
    endcase
  end

  // ---------------------------------------------------------------
  // link engine: address, command, data bytes, read-back
  // ---------------------------------------------------------------
  localparam [4:0] L_IDLE = 5'h01;
  localparam [4:0] L_RX = 5'h02;
  localparam [4:0] L_ACK = 5'h04;
  localparam [4:0] L_TX = 5'h08;
  localparam [4:0] L_RACK = 5'h10;
  reg [4:0] lst;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg exec;
  wire [7:0] tx_byte = tx_hi ? rd_word[15:8] : rd_word[7:0];

  // byte-level slave; a write runs when its stop is seen
  always @(posedge mclk_i) begin
    exec <= 1'b0;
    sda_o <= 1'b0;
    if (sys_rst_i) begin
      lst <= L_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      nbytes <= 3'h0;
      rw <= 1'b0;
      tx_hi <= 1'b0;
      cmd <= 8'h00;
      d0 <= 8'h00;
      d1 <= 8'h00;
      sda_oe_n_o <= 1'b1;
    end else if (bus_start) begin
      lst <= L_RX;
      bit_cnt <= 4'h0;
      nbytes <= 3'h0;
      sda_oe_n_o <= 1'b1;
    end else if (bus_stop) begin
      exec <= ~rw & (nbytes >= 3'h2) & ~lst[0];
      lst <= L_IDLE;
      sda_oe_n_o <= 1'b1;
    end else begin
      case (lst)
        L_IDLE: begin
          sda_oe_n_o <= 1'b1;
        end
        L_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_q[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (nbytes == 3'h0 && shreg[7:1] != SLAVE_ADDR) begin
              lst <= L_IDLE;
            end else begin
              if (nbytes == 3'h0) begin
                rw <= shreg[0];
                tx_hi <= 1'b0;
              end
              if (nbytes == 3'h1)
                cmd <= shreg;
              if (nbytes == 3'h2)
                d0 <= shreg;
              if (nbytes == 3'h3)
                d1 <= shreg;
              if (nbytes != 3'h7)
                nbytes <= nbytes + 3'h1;
              sda_oe_n_o <= 1'b0; // acknowledge
              lst <= L_ACK;
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              shreg <= {tx_byte[6:0], 1'b0};
              sda_oe_n_o <= tx_byte[7];
              bit_cnt <= 4'h1;
              lst <= L_TX;
            end else begin
              sda_oe_n_o <= 1'b1;
              lst <= L_RX;
            end
          end
        end
        L_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe_n_o <= 1'b1;
              lst <= L_RACK;
            end else begin
              sda_oe_n_o <= shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        L_RACK: begin
          if (scl_rise) begin
            if (sda_q[1])
              lst <= L_IDLE; // master ends the read
            else
              tx_hi <= ~tx_hi; // low byte first, then high
          end else if (scl_fall) begin
            shreg <= {tx_byte[6:0], 1'b0};
            sda_oe_n_o <= tx_byte[7];
            bit_cnt <= 4'h1;
            lst <= L_TX;
          end
        end
        default: begin
          lst <= L_IDLE;
          sda_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write execution
  // ---------------------------------------------------------------
  wire [2:0] ndata = nbytes - 3'h2;
  wire [3:0] wr_slot = slot_of(cmd);
  wire [3:0] d0_slot = slot_of(d0);
  wire [15:0] wr_word = {d1, d0};
  wire lock_ok = (cmd == `PS_CMD_WRITE_LOCK) || (cmd == `PS_CMD_CLEAR_FAULTS) ||
    (lock == `PS_LOCK_NONE) ||
    (lock == `PS_LOCK_BUT_OUTPUT && cmd == `PS_CMD_OUTPUT_CTRL);
  reg data_err, refused, clr_req, restart;
  reg [3:0] pst;
  integer i;

  always @(posedge mclk_i) begin
    data_err <= 1'b0;
    refused <= 1'b0;
    clr_req <= 1'b0;
    if (sys_rst_i) begin
      out_cmd_on <= 1'b1; // on after power-up
      lock <= `PS_LOCK_NONE;
      fan_ovr <= `PS_FAN_INTERNAL;
      for (i = 0; i < 8; i = i + 1) begin
        cfg[i] <= factory(i[2:0]);
        user[i] <= factory(i[2:0]);
      end
    end else if (exec && !lock_ok) begin
      refused <= 1'b1;
    end else if (exec) begin
      case (cmd)
        `PS_CMD_OUTPUT_CTRL: begin
          if (d0 == `PS_OUT_ON && ndata == 3'h1)
            out_cmd_on <= 1'b1;
          else if (d0 == `PS_OUT_OFF && ndata == 3'h1)
            out_cmd_on <= 1'b0;
          else
            data_err <= 1'b1;
        end
        `PS_CMD_CLEAR_FAULTS: clr_req <= ctrl_side;
        `PS_CMD_WRITE_LOCK: begin
          if (d0 == `PS_LOCK_NONE || d0 == `PS_LOCK_ALL || d0 == `PS_LOCK_BUT_OUTPUT)
            lock <= d0;
          else
            data_err <= 1'b1;
        end
        `PS_CMD_RST_DEF_ALL: begin
          for (i = 0; i < 8; i = i + 1)
            cfg[i] <= factory(i[2:0]);
        end
        `PS_CMD_RST_USER_ALL: begin
          for (i = 0; i < 8; i = i + 1)
            cfg[i] <= user[i];
        end
        `PS_CMD_RST_DEF_ONE: begin
          if (d0_slot[3])
            data_err <= 1'b1;
          else
            cfg[d0_slot[2:0]] <= factory(d0_slot[2:0]);
        end
        `PS_CMD_STORE_USER: begin
          if (d0_slot[3])
            data_err <= 1'b1; // lock has no slot, never saved
          else
            user[d0_slot[2:0]] <= cfg[d0_slot[2:0]];
        end
        `PS_CMD_RST_USER_ONE: begin
          if (d0_slot[3])
            data_err <= 1'b1;
          else
            cfg[d0_slot[2:0]] <= user[d0_slot[2:0]];
        end
        `PS_CMD_FAN_CFG: data_err <= (d0 != `PS_FAN_CFG_VAL);
        `PS_CMD_FAN_OVR: begin
          if (d0 == `PS_FAN_INTERNAL)
            fan_ovr <= `PS_FAN_INTERNAL;
          else if (d0 > `PS_FAN_FULL || d0 < fmin_b)
            data_err <= 1'b1;
          else
            fan_ovr <= d0;
        end
        `PS_CMD_UV_ACTION: begin
          if (d0 == `PS_RESP_LATCH_UV || d0 == `PS_RESP_RESTART_UV)
            cfg[`PS_IX_UV_ACTION] <= {8'h00, d0};
          else
            data_err <= 1'b1;
        end
        `PS_CMD_OC_ACTION: begin
          if (d0 == `PS_RESP_LATCH_OC || d0 == `PS_RESP_HICCUP_OC)
            cfg[`PS_IX_OC_ACTION] <= {8'h00, d0};
          else
            data_err <= 1'b1;
        end
        default: begin
          if (wr_slot[3] || ndata != 3'h2)
            data_err <= 1'b1; // read-only or unknown code
          else
            cfg[wr_slot[2:0]] <= wr_word;
        end
      endcase
    end
    // pin wins at restart after off, even over a set-point write that lands in the same cycle
    if (!sys_rst_i && restart && sp_pin_sel)
      cfg[`PS_IX_SETPOINT] <= vsp_b;
  end

  // ---------------------------------------------------------------
  // millisecond tick
  // ---------------------------------------------------------------
  reg [31:0] tick_cnt;
  reg tick;

  always @(posedge mclk_i) begin
    if (sys_rst_i || tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0;
      tick <= ~sys_rst_i;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // output power sequencing
  // ---------------------------------------------------------------
  localparam [3:0] P_ON = 4'h1;
  localparam [3:0] P_OFF = 4'h2;
  localparam [3:0] P_WAIT = 4'h4;
  localparam [3:0] P_LATCH = 4'h8;
  reg [16:0] wait_ms, win_ms;
  reg win_run;
  reg [1:0] retries;
  wire want_on = out_cmd_on & pin_on;
  wire [15:0] oc_lim = high_line ? cfg[`PS_IX_OC_LIMIT] : `PS_OC_LOWLINE_LIMIT;
  wire trip_ov = pst[0] && vm_b > cfg[`PS_IX_OV_LIMIT];
  wire trip_uv = pst[0] && !dropout && vm_b < cfg[`PS_IX_UV_LIMIT];
  wire trip_oc = pst[0] && im_b > oc_lim;
  wire warn_hi = pst[0] && vm_b > cfg[`PS_IX_HI_WARN];
  wire warn_lo = pst[0] && vm_b < cfg[`PS_IX_LO_WARN];

  // shutdown, retry, latch and restart
  always @(posedge mclk_i) begin
    restart <= 1'b0;
    if (sys_rst_i) begin
      pst <= P_ON;
      wait_ms <= 17'h0;
      win_ms <= 17'h0;
      win_run <= 1'b0;
      retries <= 2'h0;
    end else begin
      if (win_run && tick) begin
        if (win_ms == WINDOW_TICKS - 17'h1) begin
          win_run <= 1'b0; // window from first trip over: count starts over
          retries <= 2'h0;
        end else begin
          win_ms <= win_ms + 17'h1;
        end
      end
      if (pst[2] && tick)
        wait_ms <= wait_ms + 17'h1;
      case (pst)
        P_ON: begin
          wait_ms <= 17'h0;
          if (!want_on) begin
            pst <= P_OFF;
          end else if (trip_ov) begin
            if (!win_run) begin
              win_run <= 1'b1;
              win_ms <= 17'h0;
            end
            if (retries == `PS_OV_RETRIES) begin
              pst <= P_LATCH;
            end else begin
              retries <= retries + 2'h1;
              pst <= P_WAIT;
            end
          end else if (trip_uv) begin
            pst <= (cfg[`PS_IX_UV_ACTION][7:0] == `PS_RESP_LATCH_UV) ? P_LATCH : P_WAIT;
          end else if (trip_oc) begin
            pst <= (cfg[`PS_IX_OC_ACTION][7:0] == `PS_RESP_LATCH_OC) ? P_LATCH : P_WAIT;
          end
        end
        P_WAIT: begin
          if (!want_on)
            pst <= P_OFF;
          else if (wait_ms == RETRY_TICKS)
            pst <= P_ON; // one second between retries
        end
        P_LATCH: begin
          if (!want_on)
            pst <= P_OFF;
        end
        P_OFF: begin
          if (want_on) begin
            pst <= P_ON;
            restart <= 1'b1;
            retries <= 2'h0;
            win_run <= 1'b0;
          end
        end
        default: pst <= P_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sticky fault flags, alert and outputs
  // ---------------------------------------------------------------
  reg [7:0] flags;
  wire [7:0] flag_set = {trip_ov, warn_hi, warn_lo, trip_uv, trip_oc, data_err, pst[3], refused};
  wire [7:0] clr_mask = (clr_req || restart) ? 8'hFF : 8'h00;
  // a cause present in the clearing cycle sets its flag again
  wire [7:0] next_flags = (flags & ~clr_mask) | flag_set;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flags <= 8'h00;
      alert_n_o <= 1'b1;
      fault_flags_o <= 8'h00;
      main_on_o <= 1'b0;
      latched_off_o <= 1'b0;
      setpoint_o <= `PS_DEF_SETPOINT;
      fan_duty_o <= 8'h00;
    end else begin
      flags <= next_flags;
      fault_flags_o <= next_flags;
      alert_n_o <= ~(|next_flags);
      main_on_o <= pst[0];
      latched_off_o <= pst[3];
      setpoint_o <= cfg[`PS_IX_SETPOINT];
      fan_duty_o <= (fan_ovr == `PS_FAN_INTERNAL) ? fmin_b : fan_ovr;
    end
  end

endmodule

// ### ps_cmd_handler_asserts.sv
// port checks of the supply command handler
`timescale 1ns/1ps
module ps_cmd_chk (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire input_dropout_i,
  input wire high_line_i,
  input wire [15:0] vout_meas_i,
  input wire [15:0] iout_meas_i,
  input wire [7:0] fan_min_duty_i,
  input wire main_on_o,
  input wire [7:0] fan_duty_o,
  input wire [7:0] fault_flags_o,
  input wire latched_off_o,
  input wire alert_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // alert follows the flag byte within a cycle
  alert_set_a: assert property (fault_flags_o != 8'h00 |-> ##[0:1] !alert_n_o)
    else $error("alert not raised");
  alert_clear_a: assert property ((fault_flags_o == 8'h00) [*2] |-> alert_n_o)
    else $error("alert not released");
  fan_floor_a: assert property ((!$past(sys_rst_i, 5) && $stable(fan_min_duty_i)) [*5]
    |-> fan_duty_o >= fan_min_duty_i) else $error("fan below required duty");
  oc_lowline_a: assert property (main_on_o && !high_line_i && iout_meas_i > 16'h002D
    |-> ##[1:8] fault_flags_o[3]) else $error("low line overcurrent missed");
  ov_shut_a: assert property (main_on_o && vout_meas_i > 16'h1D9A
    |-> ##[1:8] !main_on_o) else $error("overvoltage did not shut down");
  warn_high_a: assert property (main_on_o && vout_meas_i > 16'h1B9A
    && vout_meas_i <= 16'h1D9A |-> ##[1:8] fault_flags_o[6]) else $error("no high warning");
  uv_mask_a: assert property (input_dropout_i [*4] |-> !$rose(fault_flags_o[4]))
    else $error("undervoltage flagged during dropout");
  latch_flag_a: assert property ($rose(latched_off_o)
    |-> ##[0:1] (fault_flags_o[1] && !main_on_o)) else $error("latch without flag");
endmodule

bind ps_cmd_handler ps_cmd_chk ps_cmd_chk_i (.*);

// ### ps_mst_model.sv
// link master model standing in for the system management controller
`timescale 1ns/1ps
module ps_mst_model #(
  parameter logic [6:0] ADDR = 7'h58
) (
  input wire mclk_i,
  input wire sda_i,
  output logic scl_o = 1'b1,
  output logic sda_o = 1'b1
);
  // hold clock and data for n system clocks, 8 make one 32 ns link period
  task automatic q(input logic c, input logic d, input int n);
    scl_o <= c;
    sda_o <= d;
    repeat (n) @(posedge mclk_i);
  endtask
  // one bit: data moves mid low phase, wire sampled at end of high phase
  task automatic bt(input logic b, output logic s);
    q(1'b0, sda_o, 2);
    q(1'b0, b, 2);
    q(1'b1, b, 4);
    s = sda_i;
  endtask
  // nine bits msb first, returning what the wire showed
  task automatic byt(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
      bt(d[i], r[i]);
  endtask
  // start when s is high, stop when low; clock stands high between frames
  task automatic fr(input logic s);
    q(1'b0, sda_o, 2);
    q(1'b0, s, 2);
    q(1'b1, s, 4);
    q(1'b1, ~s, 4);
  endtask
  // write command and data low byte first, then read nr bytes back
  task automatic xfer(input logic [7:0] cmd, input int nw, input logic [15:0] wd,
      input int nr, output logic [15:0] rd, output logic ak);
    logic [8:0] r;
    ak = 1'b1;
    rd = 16'h0000;
    fr(1'b1);
    byt({ADDR, 2'b01}, r);
    ak &= ~r[0];
    byt({cmd, 1'b1}, r);
    ak &= ~r[0];
    for (int i = 0; i < nw; i++) begin
      byt({wd[8*i +: 8], 1'b1}, r);
      ak &= ~r[0];
    end
    if (nr > 0) begin
      fr(1'b1);
      byt({ADDR, 2'b11}, r);
      ak &= ~r[0];
      for (int i = 0; i < nr; i++) begin
        byt({8'hFF, i == nr - 1}, r);  // acknowledge all but the last byte
        rd[8*i +: 8] = r[8:1];
      end
    end
    fr(1'b0);
  endtask
endmodule

// ### tb.sv
// self-checking bench for the supply command handler
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, ctrl_side_i = 1'b1, on_pin_i = 1'b1;
  logic high_line_i = 1'b0, input_dropout_i = 1'b0, setpoint_pin_sel_i = 1'b0, ak;
  logic [15:0] setpoint_pin_i = 16'h1700, vout_meas_i = 16'h1800, iout_meas_i = 16'h0010;
  logic [15:0] v, sp;
  logic [7:0] fan_min_duty_i = 8'h20;
  wire scl_i, m_sda, sda_o, sda_oe_n_o, main_on_o, latched_off_o, alert_n_o;
  wire [15:0] setpoint_o;
  wire [7:0] fan_duty_o, fault_flags_o;
  wire sda_i = m_sda & (sda_oe_n_o | sda_o);  // pulled up, low if either side pulls
  int error_cnt = 0, tests_run = 0;
  logic [31:0] tbl [8] = '{32'h2001_0017, 32'h3A01_0090, 32'h3502_005A, 32'h3602_0050,
    32'h4501_00C0, 32'h4701_00F8, 32'h1001_0000, 32'h2102_1800};
  always #2 mclk_i = ~mclk_i;
  ps_cmd_handler #(.TICK_CYCLES(4), .RETRY_TICKS(17'd3), .WINDOW_TICKS(17'd40))
    ps_cmd_handler_i (.*);
  ps_mst_model ps_mst_model_i (.mclk_i, .sda_i, .scl_o(scl_i), .sda_o(m_sda));
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // a write, then time for it to act
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
    ps_mst_model_i.xfer(c, n, d, 0, v, ak);
    wt(8);
    chk("write_ack", 16'h0001, ak);
  endtask
  task automatic rd(input logic [7:0] c, input int n);
    ps_mst_model_i.xfer(c, 0, 16'h0000, n, v, ak);
  endtask
  // fan duty shown for an accepted override byte
  function automatic logic [15:0] fan_exp(input logic [7:0] o);
    return (o == 8'h00) ? {8'h00, fan_min_duty_i} : {8'h00, o};
  endfunction
  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h74FC));
    fan_min_duty_i <= 8'($urandom_range(16, 64));
    sp = 16'h1600 + 16'($urandom_range(0, 1023));
    wt(6);
    sys_rst_i <= 1'b0;
    wt(4);
    chk("power_up", 16'h0201, {alert_n_o, fault_flags_o, main_on_o});
    foreach (tbl[i]) begin
      rd(tbl[i][31:24], tbl[i][23:16]);
      chk("read_table", tbl[i][15:0], v);
    end
    high_line_i <= 1'b1;
    rd(8'h35, 2);
    chk("turn_on_high", 16'h00B4, v);
    wr(8'h36, 2, 16'h0011);
    chk("ro_write", 16'h0001, fault_flags_o[2]);
    ctrl_side_i <= 1'b0;
    wr(8'h03, 0, 16'h0000);
    chk("clear_idle_side", 16'h0001, fault_flags_o[2]);
    ctrl_side_i <= 1'b1;
    wr(8'h03, 0, 16'h0000);
    chk("clear_ctrl_side", 16'h0100, {alert_n_o, fault_flags_o});
    wr(8'h3B, 1, 16'h0064);
    chk("fan_full", fan_exp(8'h64), fan_duty_o);
    wr(8'h3B, 1, {8'h00, fan_min_duty_i - 8'h01});
    chk("fan_low", 16'h00C9, {fan_duty_o, fault_flags_o[2]});
    wr(8'h3B, 1, 16'h0000);
    chk("fan_internal", fan_exp(8'h00), fan_duty_o);
    wr(8'h10, 1, 16'h0080);
    wr(8'h21, 2, sp);
    chk("lock_all", 16'h1801, {setpoint_o[15:1], fault_flags_o[0]});
    rd(8'h21, 2);
    chk("read_locked", 16'h1800, v);
    wr(8'h10, 1, 16'h0040);
    wr(8'h01, 1, 16'h0000);
    chk("lock_but_output", 16'h0000, main_on_o);
    wr(8'h10, 1, 16'h0000);
    wt(8000);  // off for at least two seconds
    wr(8'h01, 1, 16'h0080);
    chk("restart", 16'h0201, {alert_n_o, fault_flags_o, main_on_o});
    wr(8'h01, 1, 16'h0055);
    chk("bad_output_code", 16'h0003, {fault_flags_o[2], main_on_o});
    wr(8'h21, 2, sp);
    chk("setpoint", sp, setpoint_o);
    wr(8'h17, 1, 16'h0021);
    wr(8'h21, 2, sp ^ 16'h0040);
    wr(8'h18, 1, 16'h0021);
    chk("user_restore", sp, setpoint_o);
    wr(8'h14, 1, 16'h0021);
    chk("factory_one", 16'h1800, setpoint_o);
    wr(8'h21, 2, sp);
    wr(8'h12, 0, 16'h0000);
    chk("factory_all", 16'h1800, setpoint_o);
    wr(8'h16, 0, 16'h0000);
    chk("user_all", sp, setpoint_o);
    vout_meas_i <= 16'h1C00;
    wr(8'h03, 0, 16'h0000);
    chk("warn_persists", 16'h0002, {fault_flags_o[6], alert_n_o});
    vout_meas_i <= 16'h1000;
    input_dropout_i <= 1'b1;
    wr(8'h45, 1, 16'h0080);
    chk("uv_masked", 16'h0005, {fault_flags_o[5:4], main_on_o});
    input_dropout_i <= 1'b0;
    wt(20);
    chk("uv_latch", 16'h0003, {fault_flags_o[4], latched_off_o});
    vout_meas_i <= 16'h1800;
    wr(8'h01, 1, 16'h0000);
    wr(8'h01, 1, 16'h0080);
    chk("cmd_release", 16'h0201, {alert_n_o, fault_flags_o, main_on_o});
    high_line_i <= 1'b0;
    wr(8'h47, 1, 16'h00C0);
    iout_meas_i <= 16'h002E;
    wt(20);
    chk("oc_latch", 16'h0003, {fault_flags_o[3], latched_off_o});
    iout_meas_i <= 16'h0010;
    setpoint_pin_sel_i <= 1'b1;
    on_pin_i <= 1'b0;
    wt(20);
    on_pin_i <= 1'b1;
    wt(20);
    chk("pin_release", 16'h1700, setpoint_o);
    chk("pin_state", 16'h0201, {alert_n_o, fault_flags_o, main_on_o});
    vout_meas_i <= 16'h1E00;
    for (int i = 0; i < 200 && main_on_o; i++)
      wt(1);
    chk("ov_first_off", 16'h0000, {main_on_o, latched_off_o});
    for (int i = 0; i < 1000 && !latched_off_o; i++)
      wt(1);
    chk("ov_latched", 16'h0001, latched_off_o);
    summarize();
  end
  // cut a hang short well past the expected run
  initial begin
    wt(90000);
    error_cnt++;
    summarize();
  end
endmodule
